// file: hdl/swpr_defines.vh
// What this block does
// RULE1 - late second edge in slot means zero
// RULE2 - early second edge in slot means one
// RULE3 - host sends thirty slots after measuring
// RULE4 - host ends each packet with idle low
// RULE5 - long low freezes shifter, enables pass-through
// RULE6 - host latches only after all packets
// RULE7 - latch low copies grayscale, restarts pwm
// RULE8 - packet is key byte plus 24 bits
// RULE9 - host resends all packets on change
// RULE10 - outputs stay off until data latched
// RULE11 - packet arrives most significant bit first
// RULE12 - grayscale copied only when key matches
// RULE13 - host keeps one bit period for chain
// RULE14 - packets, ends, then one latch sequence
// RULE15 - first two edges measure bit period
// RULE16 - measurement shifts two zero bits in
// RULE17 - channel bytes sit at 23:16, 15:8, 7:0
// RULE18 - hold times are period multiples, latch longer
// RULE19 - synchronise input, time with wide counter
`ifndef SWPR_DEFINES_VH
`define SWPR_DEFINES_VH

// ==========================================================
// clock and link timing
`define SWPR_CLK_NS          4
`define SWPR_TCYC_MAX_NS     50000
// longest bit period in clock cycles, sized to the period counter
`define SWPR_TCYC_MAX_CYC    16'h30d4
`define SWPR_END_SHIFT       1
`define SWPR_LAT_SHIFT       3
`define SWPR_GS_DIV          6'h2a

// ==========================================================
// packet layout
`define SWPR_WRITE_KEY       8'h3a
`define SWPR_KEY_MSB         31
`define SWPR_KEY_LSB         24
`define SWPR_CH0_MSB         23
`define SWPR_CH0_LSB         16
`define SWPR_CH1_MSB         15
`define SWPR_CH1_LSB         8
`define SWPR_CH2_MSB         7
`define SWPR_CH2_LSB         0

// ==========================================================
// reset values
`define SWPR_SHIFT_RST       32'h00000000
`define SWPR_GS_RST          24'h000000
`define SWPR_PERIOD_RST      16'h0000

`endif

// file: hdl/swpr_pwm.v
`timescale 1ns/1ps
`include "swpr_defines.vh"

module swpr_pwm (
   input  wire        i_clk,      // system clock
   input  wire        i_sys_rst,  // async reset, high
   input  wire        i_load,     // new values latched
   input  wire [23:0] i_values,   // three channel values
   output reg  [2:0]  o_sink      // sink on, bit 2 first channel
);

   reg [5:0] div_r;
   reg [7:0] gs_cnt_r;
   wire      gs_tick = (div_r == `SWPR_GS_DIV - 6'h1);

   // ==========================================================
   // grayscale clock and counter
   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_r    <= 6'h00;
         gs_cnt_r <= 8'h00;
      end else if (i_load) begin
         div_r    <= 6'h00;  // RULE7
         gs_cnt_r <= 8'h00;
      end else if (gs_tick) begin
         div_r    <= 6'h00;
         gs_cnt_r <= gs_cnt_r + 8'h01;
      end else begin
         div_r    <= div_r + 6'h01;
      end
   end

   // ==========================================================
   // per channel compare
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_ch
         always @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               o_sink[g] <= 1'b0;  // RULE10
            end else if (i_load) begin
               o_sink[g] <= 1'b0;
            end else begin
               o_sink[g] <= (gs_cnt_r != 8'h00) && (gs_cnt_r <= i_values[g*8 +: 8]);
            end
         end
      end
   endgenerate

endmodule // swpr_pwm

// file: hdl/swpr_receiver.v
`timescale 1ns/1ps
`include "swpr_defines.vh"

module swpr_receiver #(
   parameter [15:0] MAX_PERIOD_CYC = `SWPR_TCYC_MAX_CYC  // longest bit period in cycles
) (
   input  wire       i_clk,                    // system clock, 250 MHz
   input  wire       i_sys_rst,                // async reset, high
   input  wire       i_serial_in_line,         // serial data from host or upstream
   output wire       o_serial_out_line,        // buffered copy to next device while held, low otherwise
   output wire       o_first_sink_output,      // first channel sink on
   output wire       o_second_sink_output,     // second channel sink on
   output wire       o_third_sink_output,      // third channel sink on
   output wire [7:0] o_first_channel_value,    // latched first channel value
   output wire [7:0] o_second_channel_value,   // latched second channel value
   output wire [7:0] o_third_channel_value,    // latched third channel value
   output reg        o_packet_end,             // packet held, pass-through on
   output reg        o_latch_sequence          // one-cycle pulse per latch sequence
);

   localparam [1:0] ST_MEAS0 = 2'b00;
   localparam [1:0] ST_MEAS1 = 2'b01;
   localparam [1:0] ST_DATA  = 2'b10;
   localparam [1:0] ST_HELD  = 2'b11;

   // hold threshold as a multiple of the learned period
   function [19:0] hold_thr;
      input [15:0] period;
      input integer sh;
      begin
         hold_thr = {4'h0, period} << sh;
      end
   endfunction

   // ==========================================================
   // input synchroniser and edge detect
   reg sync1_r;
   reg sync2_r;
   reg sync3_r;

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= i_serial_in_line;  // RULE19
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   wire rise = sync2_r & ~sync3_r;  // RULE19

   // ==========================================================
   // low interval counter
   reg [19:0] low_cnt_r;

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         low_cnt_r <= 20'h00000;
      end else if (sync2_r) begin
         low_cnt_r <= 20'h00000;
      end else if (low_cnt_r != 20'hfffff) begin
         low_cnt_r <= low_cnt_r + 20'h00001;
      end
   end

   // ==========================================================
   // receive state machine
   reg  [1:0]  state_r;
   reg  [15:0] cnt_r;
   reg  [15:0] period_r;
   reg  [31:0] shift_r;
   reg         slot_open_r;
   reg  [23:0] gs_r;
   reg         load_r;
   reg         sout_r;

   wire [15:0] half      = {1'b0, period_r[15:1]};
   wire [19:0] end_thr   = hold_thr(period_r, `SWPR_END_SHIFT);   // RULE18
   wire [19:0] lat_thr   = hold_thr(period_r, `SWPR_LAT_SHIFT);   // RULE18
   wire        end_hit   = (low_cnt_r >= end_thr);
   wire        lat_hit   = (low_cnt_r == lat_thr);
   wire        key_ok    = (shift_r[`SWPR_KEY_MSB:`SWPR_KEY_LSB] == `SWPR_WRITE_KEY);
   wire        active    = (state_r == ST_DATA) || (state_r == ST_HELD);

   always @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r          <= ST_MEAS0;
         cnt_r            <= 16'h0000;
         period_r         <= `SWPR_PERIOD_RST;
         shift_r          <= `SWPR_SHIFT_RST;
         slot_open_r      <= 1'b0;
         gs_r             <= `SWPR_GS_RST;  // RULE10
         load_r           <= 1'b0;
         sout_r           <= 1'b0;
         o_packet_end     <= 1'b0;
         o_latch_sequence <= 1'b0;
      end else begin
         load_r           <= 1'b0;
         o_latch_sequence <= 1'b0;
         if (cnt_r != 16'hffff) begin
            cnt_r <= cnt_r + 16'h0001;  // RULE19
         end
         if (active && lat_hit) begin
            // long low ends the whole write and re-arms measurement
            o_latch_sequence <= 1'b1;  // RULE7
            state_r          <= ST_MEAS0;
            slot_open_r      <= 1'b0;
            o_packet_end     <= 1'b0;
            sout_r           <= 1'b0;
            if (key_ok) begin  // RULE12
               gs_r   <= shift_r[`SWPR_CH0_MSB:`SWPR_CH2_LSB];  // RULE7
               load_r <= 1'b1;
            end
         end else begin
            case (state_r)
               ST_MEAS0: begin
                  if (rise) begin
                     cnt_r   <= 16'h0000;  // RULE15
                     state_r <= ST_MEAS1;
                  end
               end
               ST_MEAS1: begin
                  if (rise) begin
                     period_r    <= cnt_r;  // RULE15
                     shift_r     <= {shift_r[29:0], 2'b00};  // RULE16
                     slot_open_r <= 1'b0;
                     state_r     <= ST_DATA;
                  end else if (cnt_r >= MAX_PERIOD_CYC) begin
                     state_r <= ST_MEAS0;
                  end
               end
               ST_DATA: begin
                  if (end_hit) begin
                     state_r      <= ST_HELD;  // RULE5
                     o_packet_end <= 1'b1;
                     slot_open_r  <= 1'b0;
                  end else if (rise && slot_open_r && (cnt_r < half)) begin
                     shift_r     <= {shift_r[30:0], 1'b1};  // RULE2 RULE11
                     slot_open_r <= 1'b0;
                  end else if (slot_open_r && (cnt_r >= half)) begin
                     shift_r <= {shift_r[30:0], 1'b0};  // RULE1 RULE11
                     if (rise) begin
                        cnt_r <= 16'h0000;
                     end else begin
                        slot_open_r <= 1'b0;
                     end
                  end else if (rise) begin
                     slot_open_r <= 1'b1;
                     cnt_r       <= 16'h0000;
                  end
               end
               ST_HELD: begin
                  sout_r <= sync2_r;  // RULE5
               end
               default: begin
                  state_r <= ST_MEAS0;
               end
            endcase
         end
      end
   end

   assign o_serial_out_line      = sout_r;
   assign o_first_channel_value  = gs_r[`SWPR_CH0_MSB:`SWPR_CH0_LSB];  // RULE17 RULE8
   assign o_second_channel_value = gs_r[`SWPR_CH1_MSB:`SWPR_CH1_LSB];  // RULE17
   assign o_third_channel_value  = gs_r[`SWPR_CH2_MSB:`SWPR_CH2_LSB];  // RULE17

   // ==========================================================
   // pwm outputs
   wire [2:0] sink;

   swpr_pwm u_pwm (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_load    (load_r),
      .i_values  (gs_r),
      .o_sink    (sink)
   );

   assign o_first_sink_output  = sink[2];
   assign o_second_sink_output = sink[1];
   assign o_third_sink_output  = sink[0];

endmodule // swpr_receiver

// file: verification/swpr_host_model.sv
`timescale 1ns/1ps
module swpr_host (
   input  wire logic i_clk,  // bench clock
   output logic      o_line  // serial line to device
);
   initial o_line = 1'b0;
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // one rising edge, then low until the next one is due
   task automatic pulse(input int gap);
      o_line = 1'b1;
      tick(4);
      o_line = 1'b0;
      tick(gap - 4);
   endtask
   task automatic send(input logic [31:0] pkt, input int t);
      pulse(t);
      pulse(t);
      for (int i = 29; i >= 0; i--) begin
         if (pkt[i]) begin
            pulse(t / 4);
            pulse(t - t / 4);
         end else begin
            pulse(t);
         end
      end
   endtask
endmodule // swpr_host

// file: verification/swpr_receiver_chk.sv
`timescale 1ns/1ps
module swpr_chk #(parameter [15:0] MAX_PERIOD_CYC = 16'h00c8) (
   input wire       i_clk,                  // clock
   input wire       i_sys_rst,              // reset
   input wire       i_serial_in_line,       // line in
   input wire       o_serial_out_line,      // line out
   input wire       o_first_sink_output,    // sink 0
   input wire       o_second_sink_output,   // sink 1
   input wire       o_third_sink_output,    // sink 2
   input wire [7:0] o_first_channel_value,  // value 0
   input wire [7:0] o_second_channel_value, // value 1
   input wire [7:0] o_third_channel_value,  // value 2
   input wire       o_packet_end,           // held
   input wire       o_latch_sequence        // latch pulse
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire [23:0] vals = {o_first_channel_value, o_second_channel_value, o_third_channel_value};
   wire [2:0]  sinks = {o_first_sink_output, o_second_sink_output, o_third_sink_output};
   wire [2:0]  nz = {|o_first_channel_value, |o_second_channel_value, |o_third_channel_value};
   reg  [11:0] low_r;
   // raw low run length on the line, saturating
   always @(posedge i_clk or posedge i_sys_rst)
      low_r <= i_sys_rst ? 12'h000 : (i_serial_in_line ? 12'h000 : low_r + {11'h000, ~&low_r});
   a_out_idle_low: assert property (!o_packet_end |-> !o_serial_out_line)
      else $error("out line active while not held");
   a_end_after_low: assert property ($rose(o_packet_end) |-> !i_serial_in_line && low_r > 12'h020)
      else $error("hold without low time");
   a_latch_after_low: assert property (o_latch_sequence |-> !i_serial_in_line && low_r > 12'h080)
      else $error("latch without long low");
   a_latch_one_cycle: assert property (o_latch_sequence |=> !o_latch_sequence)
      else $error("latch pulse too long");
   a_end_until_latch: assert property ($fell(o_packet_end) |-> o_latch_sequence || $past(o_latch_sequence))
      else $error("hold dropped without latch");
   a_values_on_latch: assert property (vals != $past(vals) |-> o_latch_sequence)
      else $error("values changed without latch");
   a_zero_dark: assert property ((sinks & ~(nz | $past(nz) | $past(nz, 2))) == 3'b000)
      else $error("sink on with zero value");
   a_pwm_restart: assert property (o_latch_sequence && o_first_channel_value != 8'h00 |->
      ##3 !o_first_sink_output [*6] ##[1:60] o_first_sink_output) else $error("pwm did not restart");
   c_held: cover property (o_packet_end ##1 o_serial_out_line);
   c_full: cover property (o_latch_sequence && o_first_channel_value == 8'hff);
   c_sink: cover property ($rose(o_third_sink_output));
endmodule // swpr_chk
bind swpr_receiver swpr_chk #(.MAX_PERIOD_CYC(MAX_PERIOD_CYC)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_serial_in_line(i_serial_in_line), .o_serial_out_line(o_serial_out_line),
   .o_first_sink_output(o_first_sink_output), .o_second_sink_output(o_second_sink_output),
   .o_third_sink_output(o_third_sink_output), .o_first_channel_value(o_first_channel_value),
   .o_second_channel_value(o_second_channel_value), .o_third_channel_value(o_third_channel_value),
   .o_packet_end(o_packet_end), .o_latch_sequence(o_latch_sequence));

// file: verification/test_single_wire_pwm_data_receiver.sv
`timescale 1ns/1ps
module test_single_wire_pwm_data_receiver;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   wire         ser, sout, pend, lseq;
   wire  [2:0]  sink;
   wire  [23:0] vals;
   int          bad_count = 0, cmp_count = 0, cyc = 0, lat_n = 0, out_r = 0;
   logic [23:0] lf = 24'h000056, exp_gs = 24'h000000;
   swpr_host i_host (.i_clk(i_clk), .o_line(ser));
   swpr_receiver #(.MAX_PERIOD_CYC(16'h00c8)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_serial_in_line(ser), .o_serial_out_line(sout), .o_first_sink_output(sink[2]),
      .o_second_sink_output(sink[1]), .o_third_sink_output(sink[0]), .o_first_channel_value(vals[23:16]),
      .o_second_channel_value(vals[15:8]), .o_third_channel_value(vals[7:0]), .o_packet_end(pend),
      .o_latch_sequence(lseq));
   always #2 i_clk = ~i_clk;
   always @(posedge sout) out_r++;
   // latch pulses counted at the falling edge, where the flop output has settled
   always @(negedge i_clk) lat_n += int'(lseq === 1'b1);
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         test_done();
      end
   end
   function automatic logic [23:0] lfsr(input logic [23:0] s);
      return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
   endfunction
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic run(input logic [7:0] key, input logic [23:0] gs, input int t, input bit chain);
      int n0;
      n0 = lat_n;
      i_host.send({key, gs}, t);
      i_host.tick(3 * t);
      check({23'h0, pend}, 24'h000001);
      if (chain) begin
         out_r = 0;
         i_host.send({8'h3a, ~gs}, t);
         i_host.tick(3 * t);
         check(24'(out_r), 24'(36 + $countones(~gs)));
      end
      i_host.tick(9 * t);
      exp_gs = (key == 8'h3a) ? gs : exp_gs;
      check(24'(lat_n - n0), 24'h000001);
      check(vals, exp_gs);
      i_host.tick(60);
      if (exp_gs == 24'hffffff || exp_gs == 24'h000000)
         check({21'h0, sink}, {21'h0, {3{exp_gs[0]}}});
      $display("test end key %h period %0d", key, t);
   endtask
   initial begin
      logic [7:0] bad;
      repeat (6) @(negedge i_clk);
      i_sys_rst = 1'b0;
      check(vals, 24'h000000);
      run(8'h3a, 24'hffffff, 40, 1'b0);
      // stray edge with a gap past the longest period must abort the measurement
      i_host.pulse(300);
      run(8'h3a, 24'h000000, 100, 1'b0);
      repeat (24) lf = lfsr(lf);
      bad = (lf[5:0] == 6'h3a) ? 8'h3b : {2'b00, lf[5:0]};
      run(bad, lf ^ 24'h5a5a5a, 60, 1'b0);
      repeat (24) lf = lfsr(lf);
      run(8'h3a, lf, 24, 1'b1);
      i_sys_rst = 1'b1;
      i_host.tick(2);
      i_sys_rst = 1'b0;
      exp_gs = 24'h000000;
      check(vals, exp_gs);
      run(8'h3a, lf ^ 24'hffffff, 40, 1'b0);
      test_done();
   end
endmodule // test_single_wire_pwm_data_receiver
